// ==== hw/dfs_serializer.sv ====
// four-to-one serializer with word fifo, clocked by a sampled timing clock
//
// Functional notes
// - four quarter-rate lanes merge into one full-rate serial stream.
// - one serial bit leaves on each rising and falling timing clock edge.
// - divided clock output spans one four-bit word per period.
// - divided clock and serial data change on the same edge.
`timescale 1ns/100ps

// -------------------------------------------------------------------
// generic fifo, flip-flop storage
// -------------------------------------------------------------------
module dfs_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW-1:0] next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
   wire [AW-1:0] next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;

   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= next_wr_ptr;
         end
         if (pop)
         begin
            rd_ptr <= next_rd_ptr;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : dfs_fifo

// -------------------------------------------------------------------
// serializer top
// -------------------------------------------------------------------
module dfs_serializer
   import dfs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // half-rate timing clock from outside, sampled as a level
   input wire logic timing_clk_in,
   // quarter-rate parallel lanes
   input wire logic lane_zero_in,
   input wire logic lane_one_in,
   input wire logic lane_two_in,
   input wire logic lane_three_in,
   // serial side
   output logic serial_out,
   output logic quarter_rate_clk_out,
   // status
   output logic fifo_ready,
   output logic word_dropped,
   output logic word_underrun
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] tclk_sync;
   logic tclk_prev;
   dfs_word_t lane_meta;
   dfs_word_t lane_sync;
   wire dfs_word_t lane_raw = '{lane_three: lane_three_in,
                                lane_two: lane_two_in,
                                lane_one: lane_one_in,
                                lane_zero: lane_zero_in};

   always_ff @(posedge clk)
   begin
      tclk_sync <= {tclk_sync[0], timing_clk_in};
      tclk_prev <= tclk_sync[1];
      lane_meta <= lane_raw;
      lane_sync <= lane_meta;
   end

   // ---------------------------------------------------------------
   // bit timing
   // ---------------------------------------------------------------
   // without timing clock edges nothing advances
   wire bit_edge = tclk_sync[1] ^ tclk_prev;
   logic [BIT_IDX_W-1:0] bit_idx;
   wire word_start = bit_edge && (bit_idx == FIRST_BIT);
   wire next_clk_level = (bit_idx < CLK_HIGH_BITS);

   // ---------------------------------------------------------------
   // word fifo
   // ---------------------------------------------------------------
   // lanes sampled at the divided clock rising edge, one word per period
   wire push_word = word_start;
   wire in_ready;
   wire head_valid;
   wire dfs_word_t head_word;

   dfs_fifo #(
      .WIDTH(LANE_COUNT),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(push_word),
      .in_data(lane_sync),
      .in_ready(in_ready),
      .out_valid(head_valid),
      .out_data(head_word),
      .out_ready(word_start)
   );

   // ---------------------------------------------------------------
   // shifter
   // ---------------------------------------------------------------
   // underrun sends zeros rather than repeating stale data
   wire dfs_word_t load_word = head_valid ? head_word : '0;
   logic [LANE_COUNT-2:0] shift;

   always_ff @(posedge clk)
   begin
      if (reset_n == SYNC_RESET)
      begin
         bit_idx <= FIRST_BIT;
         shift <= '0;
         serial_out <= 1'b0;
         quarter_rate_clk_out <= 1'b0;
      end
      else if (bit_edge)
      begin
         bit_idx <= bit_idx + 1'b1;
         quarter_rate_clk_out <= next_clk_level;
         if (word_start)
         begin
            serial_out <= load_word.lane_zero;
            shift <= {load_word.lane_three, load_word.lane_two,
                      load_word.lane_one};
         end
         else
         begin
            serial_out <= shift[0];
            shift <= {1'b0, shift[LANE_COUNT-2:1]};
         end
      end
   end

   // ---------------------------------------------------------------
   // status
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         fifo_ready <= 1'b0;
         word_dropped <= 1'b0;
         word_underrun <= 1'b0;
      end
      else
      begin
         fifo_ready <= in_ready;
         word_dropped <= push_word && !in_ready;
         word_underrun <= word_start && !head_valid;
      end
   end
endmodule : dfs_serializer

// ==== shared/dfs_pkg.sv ====
// shared constants and types for the four-to-one serializer
package dfs_pkg;

   // ---------------------------------------------------------------
   // word layout and sizes
   // ---------------------------------------------------------------
   localparam int LANE_COUNT = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int BIT_IDX_W = 2;
   localparam logic [BIT_IDX_W-1:0] FIRST_BIT = 2'h0;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT = 2'h3;
   // quarter-rate clock is high while bits below this index go out
   localparam logic [BIT_IDX_W-1:0] CLK_HIGH_BITS = 2'h2;
   localparam logic SYNC_RESET = 1'h0;

   // lane zero sits in the low bit and is sent first
   typedef struct packed {
      logic lane_three;
      logic lane_two;
      logic lane_one;
      logic lane_zero;
   } dfs_word_t;

endpackage : dfs_pkg

// ==== dv/dfs_serializer_chk.sv ====
// port assertions for the four-to-one serializer
`timescale 1ns/100ps
module dfs_serializer_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic timing_clk_in,
   input wire logic serial_out,
   input wire logic quarter_rate_clk_out,
   input wire logic fifo_ready,
   input wire logic word_dropped,
   input wire logic word_underrun
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // sync plus edge detect lands 3 to 5 clk after a timing edge
   data_on_tick_a: assert property (
      $changed(serial_out) |->
      $past(timing_clk_in, 3) != $past(timing_clk_in, 6))
      else $error("data moved off a timing edge");
   clk_on_tick_a: assert property (
      $changed(quarter_rate_clk_out) |->
      $past(timing_clk_in, 3) != $past(timing_clk_in, 6))
      else $error("divided clock moved off a timing edge");
   clk_two_slots_a: assert property (
      $rose(quarter_rate_clk_out) |-> quarter_rate_clk_out [*8])
      else $error("divided clock high too short");
   no_drop_a: assert property (!word_dropped)
      else $error("word dropped");
   underrun_pulse_a: assert property (
      word_underrun |=> !word_underrun) else $error("underrun too long");
   ready_after_reset_a: assert property (
      $rose(reset_n) |=> fifo_ready) else $error("fifo not ready");
endmodule : dfs_serializer_chk

bind dfs_serializer dfs_serializer_chk i_dfs_serializer_chk (
   .clk(clk),
   .reset_n(reset_n),
   .timing_clk_in(timing_clk_in),
   .serial_out(serial_out),
   .quarter_rate_clk_out(quarter_rate_clk_out),
   .fifo_ready(fifo_ready),
   .word_dropped(word_dropped),
   .word_underrun(word_underrun)
);

// ==== dv/dfs_source.sv ====
// upstream model: timing clock and lane words
`timescale 1ns/100ps
module dfs_source
   import dfs_pkg::*;
(
   input wire logic clk,
   input wire logic run,
   input wire logic quarter_rate_clk_out,
   output logic timing_clk_in,
   output dfs_word_t lanes
);
   logic [3:0] n = 4'h0;
   logic [2:0] cnt = 3'h0;
   logic prev = 1'h0;
   initial timing_clk_in = 1'h0;
   assign lanes = n;
   // half period of 6 clk keeps every slot well past the sync latency
   always @(negedge clk)
   begin
      prev <= quarter_rate_clk_out;
      if (!run)
      begin
         timing_clk_in <= 1'h0;
         cnt <= 3'h0;
         n <= 4'h0;
      end
      else
      begin
         cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
         if (cnt == 3'h5)
            timing_clk_in <= !timing_clk_in;
         if (prev && !quarter_rate_clk_out)
            n <= n + 4'h1;
      end
   end
endmodule : dfs_source

// ==== dv/test_dfs_serializer.sv ====
// self-checking bench for the four-to-one serializer
`timescale 1ns/100ps
module test_dfs_serializer import dfs_pkg::*;;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic run = 1'h0;
   logic timing_clk_in, serial_out, quarter_rate_clk_out;
   logic fifo_ready, word_dropped, word_underrun;
   dfs_word_t lanes;
   int n_errors = 0;
   int num_checks = 0;
   int n_under = 0;
   int n_drop = 0;
   always #10 clk = !clk;
   dfs_serializer i_dfs_serializer (.clk(clk), .reset_n(reset_n),
      .timing_clk_in(timing_clk_in), .lane_zero_in(lanes.lane_zero),
      .lane_one_in(lanes.lane_one), .lane_two_in(lanes.lane_two),
      .lane_three_in(lanes.lane_three), .serial_out(serial_out),
      .quarter_rate_clk_out(quarter_rate_clk_out), .fifo_ready(fifo_ready),
      .word_dropped(word_dropped), .word_underrun(word_underrun));
   dfs_source i_dfs_source (.clk(clk), .run(run),
      .quarter_rate_clk_out(quarter_rate_clk_out),
      .timing_clk_in(timing_clk_in), .lanes(lanes));
   always @(posedge clk)
   begin
      if (word_underrun === 1'h1)
         n_under++;
      if (word_dropped !== 1'h0)
         n_drop++;
   end
   task check(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %b want %b", $time, got, exp);
      end
   endtask : check
   task conclude;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // first word after reset is an underrun, so data trails one word
   task run_stream;
      logic [3:0] w;
      reset_n = 1'h0;
      // source samples run on this same edge, so no race
      run <= 1'h0;
      repeat (8) @(negedge clk);
      check(serial_out | quarter_rate_clk_out | fifo_ready, 1'h0);
      reset_n = 1'h1;
      n_under = 0;
      n_drop = 0;
      @(negedge clk);
      check(fifo_ready, 1'h1);
      run <= 1'h1;
      for (int p = 0; p < 18; p++)
      begin
         w = (p == 0) ? 4'h0 : 4'(p - 1);
         for (int s = 0; s < 4; s++)
         begin
            @(timing_clk_in);
            repeat (5) @(negedge clk);
            check(quarter_rate_clk_out, s < 2);
            check(serial_out, w[s]);
            check(fifo_ready, 1'h1);
         end
      end
      check(n_under == 1, 1'h1);
      check(n_drop == 0, 1'h1);
   endtask : run_stream
   initial
   begin
      run_stream();
      // second pass resets while the stream is still running
      run_stream();
      conclude();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule : test_dfs_serializer
